// ### hw/sdmp_defines.svh
// Constants for the SDRAM memory port.
// Operation
// - One active-low select per memory row.
// - Mask lines: read output enable, write byte mask.
// - Shared 14-bit address, bits 9:0 and 12:11 inverted.
// - Only address set B drives memory.
// - Active-low write enable qualifies data writes.
// - Row strobe opens rows and precharges.
// - Column strobe performs column reads and writes.
// - Six independent clock enables; low means power-down.
// - 64-bit unterminated data bus to memory.
// - Check-bit lines carry no meaningful data.
// - Suspend drives clock enables into self-refresh.
`ifndef SDMP_DEFINES_SVH
`define SDMP_DEFINES_SVH
`define SDMP_ROWS        6
`define SDMP_ADDR_W      14
`define SDMP_DATA_W      64
`define SDMP_MASK_W      8
`define SDMP_ADDR_INV    14'h1BFF
`define SDMP_CMD_NOP     3'h7
`define SDMP_CMD_ACT     3'h3
`define SDMP_CMD_RD      3'h5
`define SDMP_CMD_WR      3'h4
`define SDMP_CMD_PRE     3'h2
`define SDMP_CMD_REF     3'h1
`define SDMP_CMD_MRS     3'h0
`define SDMP_PRE_ALL_BIT 10
`define SDMP_TRCD_CYC    2
`define SDMP_TRP_CYC     2
`define SDMP_CAS_CYC     2
`endif

// ### hw/sdmp_pkg.sv
// Types for the SDRAM memory port.
package sdmp_pkg;
  typedef enum logic [6:0] {
    SDMP_IDLE    = 7'h01,
    SDMP_ACT     = 7'h02,
    SDMP_RCD     = 7'h04,
    SDMP_COL     = 7'h08,
    SDMP_RDWAIT  = 7'h10,
    SDMP_PRE     = 7'h20,
    SDMP_SUSPEND = 7'h40
  } sdmp_state_t;

  typedef enum logic [2:0] {
    SDMP_OP_READ  = 3'h1,
    SDMP_OP_WRITE = 3'h2,
    SDMP_OP_REF   = 3'h4
  } sdmp_op_t;
endpackage

// ### hw/sdmp_cmd_enc.sv
// Command pin encoder for the SDRAM memory port.
`timescale 1ns/1ps
`default_nettype none
`include "sdmp_defines.svh"
module sdmp_cmd_enc (
  input  wire logic [2:0]              i_cmd,
  input  wire logic [`SDMP_ROWS-1:0]   i_row_onehot,
  input  wire logic [`SDMP_ADDR_W-1:0] i_addr,
  output logic      [`SDMP_ROWS-1:0]   o_row_select_n,
  output logic                         o_row_strobe_n,
  output logic                         o_col_strobe_n,
  output logic                         o_mem_write_en_n,
  output logic      [`SDMP_ADDR_W-1:0] o_addr_pins
);
  // Select low only for the rows set in i_row_onehot and only for a real command.
  always_comb begin
    o_row_select_n   = (i_cmd == `SDMP_CMD_NOP) ? {`SDMP_ROWS{1'b1}} : ~i_row_onehot;
    o_row_strobe_n   = i_cmd[2];
    o_col_strobe_n   = i_cmd[1];
    o_mem_write_en_n = i_cmd[0];
    o_addr_pins      = i_addr ^ `SDMP_ADDR_INV;
  end
endmodule
`default_nettype wire

// ### hw/sdmp_port.sv
// SDRAM memory port: sequences row, column and power commands onto the pins.
`timescale 1ns/1ps
`default_nettype none
`include "sdmp_defines.svh"
module sdmp_port #(
  parameter int ROWS = `SDMP_ROWS
) (
  input  wire logic                         I_SYS_CLK,
  input  wire logic                         I_SRST,
  input  wire logic                         I_REQ,
  input  wire logic [2:0]                   I_OP,
  input  wire logic [2:0]                   I_ROW,
  input  wire logic [1:0]                   I_BANK,
  input  wire logic [12:0]                  I_ROW_ADDR,
  input  wire logic [9:0]                   I_COL_ADDR,
  input  wire logic [`SDMP_DATA_W-1:0]      I_WDATA,
  input  wire logic [`SDMP_MASK_W-1:0]      I_WMASK,
  input  wire logic [ROWS-1:0]              I_PWR_DOWN,
  input  wire logic                         I_SUSPEND,
  input  wire logic [`SDMP_DATA_W-1:0]      I_MEM_DATA_BUS_IN,
  input  wire logic [`SDMP_MASK_W-1:0]      I_MEM_CHECK_BITS_IN,
  output logic                              O_READY,
  output logic                              O_RVALID,
  output logic      [`SDMP_DATA_W-1:0]      O_RDATA,
  output logic      [ROWS-1:0]              O_ROW_SELECT_N,
  output logic      [`SDMP_MASK_W-1:0]      O_BYTE_MASK,
  output logic      [`SDMP_ADDR_W-1:0]      O_MEM_ADDR_SET_B,
  output logic                              O_MEM_WRITE_EN_N,
  output logic                              O_ROW_STROBE_N,
  output logic                              O_COL_STROBE_N,
  output logic      [ROWS-1:0]              O_CKE,
  output logic      [`SDMP_DATA_W-1:0]      O_MEM_DATA_BUS,
  output logic                              O_MEM_DATA_BUS_OE,
  output logic      [`SDMP_MASK_W-1:0]      O_MEM_CHECK_BITS,
  output logic                              O_MEM_CHECK_BITS_OE
);
  // ------------------------------------------------------------------
  // Input synchronisers for the data pins.
  // ------------------------------------------------------------------
  logic [`SDMP_DATA_W-1:0] din_s1_reg, din_s2_reg;
  always_ff @(posedge I_SYS_CLK) begin
    din_s1_reg <= I_MEM_DATA_BUS_IN;
    din_s2_reg <= din_s1_reg;
  end

  // ------------------------------------------------------------------
  // Sequencer.
  // ------------------------------------------------------------------
  sdmp_pkg::sdmp_state_t state_reg, state_next;
  logic [2:0]              cnt_reg, cnt_next;
  logic [2:0]              op_reg, op_next;
  logic [ROWS-1:0]         rowsel_reg, rowsel_next;
  logic [1:0]              bank_reg, bank_next;
  logic [12:0]             raddr_reg, raddr_next;
  logic [9:0]              caddr_reg, caddr_next;
  logic [`SDMP_DATA_W-1:0] wdata_reg, wdata_next;
  logic [`SDMP_MASK_W-1:0] wmask_reg, wmask_next;
  logic [2:0]              cmd;
  logic [`SDMP_ADDR_W-1:0] addr_log;
  logic [`SDMP_MASK_W-1:0] mask_c;
  logic                    drive_c, rvalid_c;
  logic [ROWS-1:0]         cke_c;

  function automatic logic [ROWS-1:0] row_decode(input logic [2:0] r);
    row_decode = '0;
    for (int i = 0; i < ROWS; i++) begin
      if (r == 3'(i)) begin
        row_decode[i] = 1'b1;
      end
    end
  endfunction

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    op_next     = op_reg;
    rowsel_next = rowsel_reg;
    bank_next   = bank_reg;
    raddr_next  = raddr_reg;
    caddr_next  = caddr_reg;
    wdata_next  = wdata_reg;
    wmask_next  = wmask_reg;
    cmd         = `SDMP_CMD_NOP;
    addr_log    = '0;
    mask_c      = {`SDMP_MASK_W{1'b1}};
    drive_c     = 1'b0;
    rvalid_c    = 1'b0;
    cke_c       = ~I_PWR_DOWN;
    case (state_reg)
      sdmp_pkg::SDMP_IDLE: begin
        if (I_SUSPEND) begin
          // Refresh-all with the clock enables dropping at the same edge enters self-refresh.
          cmd         = `SDMP_CMD_REF;
          cke_c       = '0;
          rowsel_next = {ROWS{1'b1}};
          state_next  = sdmp_pkg::SDMP_SUSPEND;
        end else if (I_REQ && I_OP == sdmp_pkg::SDMP_OP_REF) begin
          cmd         = `SDMP_CMD_REF;
          rowsel_next = {ROWS{1'b1}};
        end else if (I_REQ) begin
          op_next     = I_OP;
          rowsel_next = row_decode(I_ROW);
          bank_next   = I_BANK;
          raddr_next  = I_ROW_ADDR;
          caddr_next  = I_COL_ADDR;
          wdata_next  = I_WDATA;
          wmask_next  = I_WMASK;
          state_next  = sdmp_pkg::SDMP_ACT;
        end
      end
      sdmp_pkg::SDMP_ACT: begin
        cmd        = `SDMP_CMD_ACT;
        addr_log   = {1'b0, raddr_reg};
        cnt_next   = 3'(`SDMP_TRCD_CYC - 1);
        state_next = sdmp_pkg::SDMP_RCD;
      end
      sdmp_pkg::SDMP_RCD: begin
        if (cnt_reg == 3'h0) begin
          state_next = sdmp_pkg::SDMP_COL;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      sdmp_pkg::SDMP_COL: begin
        addr_log = {bank_reg, 2'h0, caddr_reg};
        if (op_reg == sdmp_pkg::SDMP_OP_WRITE) begin
          cmd        = `SDMP_CMD_WR;
          mask_c     = wmask_reg;
          drive_c    = 1'b1;
          cnt_next   = 3'(`SDMP_TRP_CYC - 1);
          state_next = sdmp_pkg::SDMP_PRE;
        end else begin
          cmd        = `SDMP_CMD_RD;
          mask_c     = '0;
          // Read data also passes the two input synchroniser stages.
          cnt_next   = 3'(`SDMP_CAS_CYC + 2);
          state_next = sdmp_pkg::SDMP_RDWAIT;
        end
      end
      sdmp_pkg::SDMP_RDWAIT: begin
        mask_c = '0;
        if (cnt_reg == 3'h0) begin
          rvalid_c   = 1'b1;
          cnt_next   = 3'(`SDMP_TRP_CYC - 1);
          state_next = sdmp_pkg::SDMP_PRE;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      sdmp_pkg::SDMP_PRE: begin
        if (cnt_reg == 3'h0) begin
          cmd        = `SDMP_CMD_PRE;
          addr_log   = 14'(1) << `SDMP_PRE_ALL_BIT;
          state_next = sdmp_pkg::SDMP_IDLE;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      sdmp_pkg::SDMP_SUSPEND: begin
        cke_c = '0;
        if (!I_SUSPEND) begin
          state_next = sdmp_pkg::SDMP_IDLE;
        end
      end
      default: begin
        state_next = sdmp_pkg::SDMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      state_reg  <= sdmp_pkg::SDMP_IDLE;
      cnt_reg    <= 3'h0;
      op_reg     <= 3'h0;
      rowsel_reg <= '0;
      bank_reg   <= 2'h0;
      raddr_reg  <= 13'h0000;
      caddr_reg  <= 10'h000;
      wdata_reg  <= '0;
      wmask_reg  <= '0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      op_reg     <= op_next;
      rowsel_reg <= rowsel_next;
      bank_reg   <= bank_next;
      raddr_reg  <= raddr_next;
      caddr_reg  <= caddr_next;
      wdata_reg  <= wdata_next;
      wmask_reg  <= wmask_next;
    end
  end

  // ------------------------------------------------------------------
  // Pin encoding and output registers.
  // ------------------------------------------------------------------
  logic [ROWS-1:0]         sel_n_c;
  logic                    ras_n_c, cas_n_c, we_n_c;
  logic [`SDMP_ADDR_W-1:0] pins_c;
  logic [ROWS-1:0]         sel_src;

  // A refresh issued straight from idle uses all rows.
  assign sel_src = (state_reg == sdmp_pkg::SDMP_IDLE) ? {ROWS{1'b1}} : rowsel_reg;

  sdmp_cmd_enc u_enc (
    .i_cmd            (cmd),
    .i_row_onehot     (sel_src),
    .i_addr           (addr_log),
    .o_row_select_n   (sel_n_c),
    .o_row_strobe_n   (ras_n_c),
    .o_col_strobe_n   (cas_n_c),
    .o_mem_write_en_n (we_n_c),
    .o_addr_pins      (pins_c)
  );

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_ROW_SELECT_N      <= {ROWS{1'b1}};
      O_ROW_STROBE_N      <= 1'b1;
      O_COL_STROBE_N      <= 1'b1;
      O_MEM_WRITE_EN_N    <= 1'b1;
      O_MEM_ADDR_SET_B    <= `SDMP_ADDR_INV;
      O_BYTE_MASK         <= {`SDMP_MASK_W{1'b1}};
      O_CKE               <= '0;
      O_MEM_DATA_BUS      <= '0;
      O_MEM_DATA_BUS_OE   <= 1'b0;
      O_MEM_CHECK_BITS    <= '0;
      O_MEM_CHECK_BITS_OE <= 1'b0;
      O_READY             <= 1'b0;
      O_RVALID            <= 1'b0;
      O_RDATA             <= '0;
    end else begin
      O_ROW_SELECT_N      <= sel_n_c;
      O_ROW_STROBE_N      <= ras_n_c;
      O_COL_STROBE_N      <= cas_n_c;
      O_MEM_WRITE_EN_N    <= we_n_c;
      O_MEM_ADDR_SET_B    <= pins_c;
      O_BYTE_MASK         <= mask_c;
      O_CKE               <= cke_c;
      O_MEM_DATA_BUS      <= drive_c ? wdata_reg : '0;
      O_MEM_DATA_BUS_OE   <= drive_c;
      O_MEM_CHECK_BITS    <= '0;
      O_MEM_CHECK_BITS_OE <= 1'b0;
      O_READY             <= (state_next == sdmp_pkg::SDMP_IDLE) && !I_SUSPEND;
      O_RVALID            <= rvalid_c;
      O_RDATA             <= rvalid_c ? din_s2_reg : O_RDATA;
    end
  end

  // ------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------
  sequence s_activate;
    !O_ROW_STROBE_N && O_COL_STROBE_N && O_MEM_WRITE_EN_N;
  endsequence

  sequence s_refresh;
    !O_ROW_STROBE_N && !O_COL_STROBE_N && O_MEM_WRITE_EN_N;
  endsequence

  sequence s_read;
    O_ROW_STROBE_N && !O_COL_STROBE_N && O_MEM_WRITE_EN_N;
  endsequence

  a_write_data_qual: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    O_MEM_DATA_BUS_OE |-> (!O_MEM_WRITE_EN_N && !O_COL_STROBE_N && O_ROW_STROBE_N))
    else $error("Data driven without a write command.");
  a_select_one_row: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    s_activate |-> $onehot(~O_ROW_SELECT_N))
    else $error("Activate must select exactly one row.");
  a_read_mask_low: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    s_read |-> (O_BYTE_MASK == '0))
    else $error("Read must enable all byte outputs.");
  a_col_after_act: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    s_activate |-> ##3 !O_COL_STROBE_N)
    else $error("Column command not three cycles after activate.");
  a_precharge_close: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (!O_COL_STROBE_N && !O_MEM_WRITE_EN_N) |-> ##2 (!O_ROW_STROBE_N && !O_MEM_WRITE_EN_N))
    else $error("Write not followed by precharge.");
  a_addr_invert: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (O_ROW_SELECT_N == {ROWS{1'b1}}) |-> (O_MEM_ADDR_SET_B == `SDMP_ADDR_INV))
    else $error("Idle address pins not at inverted zero.");
  a_suspend_cke: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (state_reg == sdmp_pkg::SDMP_SUSPEND) |=> (O_CKE == '0))
    else $error("Clock enables high during suspend.");
  a_check_idle: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !O_MEM_CHECK_BITS_OE && (O_MEM_CHECK_BITS == '0))
    else $error("Check bits driven.");
  a_cke_follow: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    ((state_reg != sdmp_pkg::SDMP_SUSPEND) &&
     !((state_reg == sdmp_pkg::SDMP_IDLE) && I_SUSPEND)) |=> (O_CKE == ~$past(I_PWR_DOWN)))
    else $error("Clock enable does not follow power-down request.");
  a_cmd_encode: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (O_ROW_SELECT_N == {ROWS{1'b1}}) |-> (O_ROW_STROBE_N && O_COL_STROBE_N))
    else $error("Strobe active without select.");
  a_selfref_entry: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (state_reg == sdmp_pkg::SDMP_SUSPEND) ##0 s_refresh |-> (O_CKE == '0))
    else $error("Refresh into suspend left clock enables high.");
  a_refresh_rows: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    s_refresh |-> (O_ROW_SELECT_N == '0))
    else $error("Refresh must select every row.");
  a_read_return: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    s_read |-> ##5 O_RVALID)
    else $error("Read data not returned five cycles after column read.");
endmodule
`default_nettype wire

// ### test/sdmp_mem_model.sv
// Behavioural SDRAM rows that answer the memory port pins.
`timescale 1ns/1ps
`default_nettype none
`include "sdmp_defines.svh"
module sdmp_mem_model (
  input  wire logic        i_clk,
  input  wire logic [5:0]  i_sel_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [13:0] i_addr,
  input  wire logic [7:0]  i_mask,
  input  wire logic [63:0] i_dq,
  input  wire logic        i_dq_oe,
  output logic      [63:0] o_dq
);
  logic [63:0] mem [logic [27:0]];
  logic [12:0] open_row [6];
  logic [13:0] la;
  logic [63:0] pend;
  logic        pend_v;
  logic [63:0] cur;
  logic [27:0] key;
  int          r;
  int          b;
  initial begin
    o_dq = 64'h0;
    pend_v = 1'b0;
  end
  // A released bus shows the inverse of its last value, never a stale copy.
  always @(posedge i_clk) begin
    la = i_addr ^ `SDMP_ADDR_INV;
    o_dq <= pend_v ? pend : ~o_dq;
    pend_v <= 1'b0;
    for (r = 0; r < 6; r++) begin
      if (!i_sel_n[r]) begin
        case ({i_ras_n, i_cas_n, i_we_n})
          `SDMP_CMD_ACT: open_row[r] = la[12:0];
          `SDMP_CMD_RD: begin
            key = {r[2:0], la[13:12], open_row[r], la[9:0]};
            pend <= mem.exists(key) ? mem[key] : 64'h0;
            pend_v <= 1'b1;
          end
          `SDMP_CMD_WR: begin
            key = {r[2:0], la[13:12], open_row[r], la[9:0]};
            cur = mem.exists(key) ? mem[key] : 64'h0;
            for (b = 0; b < 8; b++) begin
              if (!i_mask[b] && i_dq_oe) begin
                cur[b*8+:8] = i_dq[b*8+:8];
              end
            end
            mem[key] = cur;
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the SDRAM memory port.
`timescale 1ns/1ps
`default_nettype none
`include "sdmp_defines.svh"
module tb;
  logic        clk, srst, req, sus, rdy, rv, we_n, ras_n, cas_n, dq_oe, ecc_oe;
  logic [2:0]  op, row;
  logic [1:0]  bank;
  logic [12:0] ra;
  logic [9:0]  ca;
  logic [63:0] wd, dq_in, rdata, dq;
  logic [7:0]  wm, bmask, ecc;
  logic [5:0]  pd, sel_n, cke;
  logic [13:0] addr, la;
  int          bad_count, checks_done, refs, n, i;
  logic [63:0] exp_mem [logic [27:0]];
  sdmp_port #(.ROWS(6)) DUT (.I_SYS_CLK(clk), .I_SRST(srst), .I_REQ(req), .I_OP(op),
    .I_ROW(row), .I_BANK(bank), .I_ROW_ADDR(ra), .I_COL_ADDR(ca), .I_WDATA(wd),
    .I_WMASK(wm), .I_PWR_DOWN(pd), .I_SUSPEND(sus), .I_MEM_DATA_BUS_IN(dq_in),
    .I_MEM_CHECK_BITS_IN(8'h00), .O_READY(rdy), .O_RVALID(rv), .O_RDATA(rdata),
    .O_ROW_SELECT_N(sel_n), .O_BYTE_MASK(bmask), .O_MEM_ADDR_SET_B(addr),
    .O_MEM_WRITE_EN_N(we_n), .O_ROW_STROBE_N(ras_n), .O_COL_STROBE_N(cas_n),
    .O_CKE(cke), .O_MEM_DATA_BUS(dq), .O_MEM_DATA_BUS_OE(dq_oe),
    .O_MEM_CHECK_BITS(ecc), .O_MEM_CHECK_BITS_OE(ecc_oe));
  sdmp_mem_model u_mem (.i_clk(clk), .i_sel_n(sel_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .i_addr(addr), .i_mask(bmask), .i_dq(dq), .i_dq_oe(dq_oe), .o_dq(dq_in));
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [63:0] merge(logic [63:0] o, logic [63:0] d, logic [7:0] m);
    for (int b = 0; b < 8; b++) if (!m[b]) o[b*8+:8] = d[b*8+:8];
    return o;
  endfunction
  task automatic wait_rdy;
    n = 0;
    while (rdy !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // ----------------------------------------
  // Pin monitor: activate, write and read commands are checked against the request held at the inputs, precharge and refresh against fixed values.
  // ----------------------------------------
  always @(posedge clk) begin
    la = addr ^ `SDMP_ADDR_INV;
    if (!srst) begin
      case ({ras_n, cas_n, we_n})
        `SDMP_CMD_ACT: begin
          chk("act select", {58'h0, ~(6'h01 << row)}, {58'h0, sel_n});
          chk("act addr", {1'b0, ra} ^ `SDMP_ADDR_INV, addr);
          chk("act oe", 0, dq_oe);
        end
        `SDMP_CMD_PRE: begin
          chk("pre addr", (14'(1) << `SDMP_PRE_ALL_BIT) ^ `SDMP_ADDR_INV, addr);
        end
        `SDMP_CMD_WR: begin
          chk("wr data", wd, dq);
          chk("wr mask", wm, bmask);
          chk("wr oe", 1, dq_oe);
        end
        `SDMP_CMD_RD: begin
          chk("rd mask", 0, bmask);
          chk("rd col", {bank, ca}, {la[13:12], la[9:0]});
        end
        `SDMP_CMD_REF: begin
          refs++;
          chk("ref select", 0, sel_n);
          chk("check bits oe", 0, ecc_oe);
          chk("check bits", 0, ecc);
        end
        default: ;
      endcase
    end
  end
  task automatic acc(input logic [2:0] o, input logic [2:0] r, input logic [1:0] b,
                     input logic [12:0] a, input logic [9:0] c, input logic [63:0] d,
                     input logic [7:0] m);
    logic [27:0] k;
    logic [63:0] e;
    k = {r, b, a, c};
    e = exp_mem.exists(k) ? exp_mem[k] : 64'h0;
    wait_rdy();
    {op, row, bank, ra, ca, wd, wm} = {o, r, b, a, c, d, m};
    req = 1'b1;
    @(posedge clk);
    #1;
    req = 1'b0;
    if (o == 3'h1) begin
      n = 0;
      while (rv !== 1'b1 && n < 30) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("rvalid", 1, rv);
      chk("read data", e, rdata);
    end else if (o == 3'h2) begin
      exp_mem[k] = merge(e, d, m);
    end else begin
      // A refresh reaches the pins one edge later and the monitor one edge after that.
      repeat (2) @(posedge clk);
      #1;
    end
    wait_rdy();
    chk("ready", 1, rdy);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    srst = 1'b1;
    {req, sus, op, row, bank, ra, ca, wd, wm, pd} = '0;
    {bad_count, checks_done, refs} = 0;
    void'($urandom(32'h46B1));
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    acc(3'h2, 3'h5, 2'h3, 13'h1FFF, 10'h3FF, 64'hA5A5_0123_4567_89AB, 8'h00);
    acc(3'h2, 3'h5, 2'h3, 13'h1FFF, 10'h3FF, 64'hFFFF_FFFF_0000_0000, 8'hF0);
    acc(3'h1, 3'h5, 2'h3, 13'h1FFF, 10'h3FF, 64'h0, 8'h00);
    acc(3'h2, 3'h0, 2'h0, 13'h0000, 10'h000, 64'hFFFF_FFFF_FFFF_FFFF, 8'hFF);
    acc(3'h1, 3'h0, 2'h0, 13'h0000, 10'h000, 64'h0, 8'h00);
    acc(3'h4, 3'h2, 2'h1, 13'h0001, 10'h001, 64'h0, 8'h00);
    chk("refresh count", 1, refs);
    for (i = 0; i < 60; i++) begin
      acc(3'h1 << ($urandom % 3), 3'($urandom % 6), 2'($urandom), 13'($urandom % 3),
          10'($urandom % 4), {$urandom, $urandom}, 8'($urandom));
    end
    pd = 6'($urandom);
    repeat (3) @(posedge clk);
    #1;
    chk("cke power down", {58'h0, ~pd}, {58'h0, cke});
    n = refs;
    sus = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("cke suspend", 0, cke);
    chk("suspend refresh", 1, refs > n);
    chk("ready in suspend", 0, rdy);
    sus = 1'b0;
    wait_rdy();
    @(posedge clk);
    #1;
    chk("cke resume", {58'h0, ~pd}, {58'h0, cke});
    test_done();
  end
endmodule
`default_nettype wire
